// ---- shared/dvr_regs.svh ----
// register addresses, field positions and reset values of the command block
`ifndef DVR_REGS_SVH
`define DVR_REGS_SVH

`define DVR_A_DATA 4'h0
`define DVR_A_ERR 4'h1
`define DVR_A_SCNT 4'h2
`define DVR_A_SNUM 4'h3
`define DVR_A_CYLL 4'h4
`define DVR_A_CYLH 4'h5
`define DVR_A_DEVH 4'h6
`define DVR_A_CMD 4'h7
`define DVR_A_DEVCTL 4'h8

`define DVR_OP_VERIFY_EXT 8'h42
`define DVR_OP_RECAL_NIB 4'h1

`define DVR_E_UNCORRECTABLE 6
`define DVR_E_SECTOR_ID_MISSING 4
`define DVR_E_ABORTED 2
`define DVR_E_TRACK_ZERO_MISSING 1

`define DVR_S_BUSY 7
`define DVR_S_READY 6
`define DVR_S_SEEK_DONE 4
`define DVR_S_DRQ 3
`define DVR_S_ERROR 0

`define DVR_DC_HIGH_BYTE_SELECT 7

`define DVR_RST_BYTE 8'h00
`define DVR_MAX_SECTORS 17'h10000

`endif

// ---- shared/dvr_pkg.sv ----
// types shared by the command sequencer and the range walker
package dvr_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_VREQ  = 5'b00010,
    ST_VWAIT = 5'b00100,
    ST_SREQ  = 5'b01000,
    ST_SWAIT = 5'b10000
  } dvr_state_t;
endpackage

// ---- shared/dvr_walk_if.sv ----
// carrier between the sequencer and the sector range walker
interface dvr_walk_if #(
  parameter int LBA_W = 48,
  parameter int CNT_W = 16
);
  logic load;
  logic step;
  logic [LBA_W-1:0] start_lba;
  logic [CNT_W-1:0] start_cnt;
  logic [LBA_W-1:0] cur_lba;
  logic last;

  modport ctl (output load, output step, output start_lba,
    output start_cnt, input cur_lba, input last);
  modport walk (input load, input step, input start_lba,
    input start_cnt, output cur_lba, output last);
endinterface

// ---- design/dvr_range_walk.sv ----
// sector range walker: current address and sectors left
`include "dvr_regs.svh"
module dvr_range_walk
  import dvr_pkg::*;
#(
  parameter int LBA_W = 48,
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // sequencer side
  dvr_walk_if.walk wk
);
  generate
    if (LBA_W != 48 || CNT_W != 16) begin : g_bad_width
      $error("dvr_range_walk: only 48-bit address, 16-bit count");
    end
  endgenerate

  logic [LBA_W-1:0] lba_r;
  logic [LBA_W-1:0] lba_nxt;
  logic [CNT_W:0] left_r;
  logic [CNT_W:0] left_nxt;

  always_comb begin
    lba_nxt = lba_r;
    left_nxt = left_r;
    if (wk.load) begin
      lba_nxt = wk.start_lba;
      // a zero count means the full 16-bit range
      left_nxt = (wk.start_cnt == '0) ? `DVR_MAX_SECTORS :
        {1'b0, wk.start_cnt};
    end else if (wk.step) begin
      lba_nxt = lba_r + {{(LBA_W-1){1'b0}}, 1'b1};
      left_nxt = left_r - {{CNT_W{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lba_r <= '0;
      left_r <= '0;
    end else if (ce_i) begin
      lba_r <= lba_nxt;
      left_r <= left_nxt;
    end
  end

  assign wk.cur_lba = lba_r;
  assign wk.last = (left_r == {{CNT_W{1'b0}}, 1'b1});

  a_count_load: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wk.load && wk.start_cnt != '0)
      |=> left_r == {1'b0, $past(wk.start_cnt)})
    else $error("sector count not assembled from load");

  a_zero_count: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wk.load && wk.start_cnt == '0) |=> left_r == 17'h10000)
    else $error("zero count did not become 65536");
endmodule // dvr_range_walk

// ---- design/dvr_cmd_top.sv ----
// command-block registers with verify-ext and recalibrate sequencing
`include "dvr_regs.svh"
module dvr_cmd_top
  import dvr_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // command-block register port
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [3:0] tf_addr_i,
  input wire logic [7:0] tf_wdata_i,
  output logic [7:0] tf_rdata_o,
  output logic busy_o,
  // medium verify engine
  output logic vfy_req_o,
  output logic [47:0] vfy_lba_o,
  input wire logic vfy_done_i,
  input wire logic vfy_uncorr_i,
  input wire logic vfy_id_missing_i,
  // head positioner
  output logic seek_req_o,
  input wire logic seek_done_i,
  input wire logic seek_fail_i
);
  dvr_state_t state_r;
  dvr_state_t state_nxt;
  logic [7:0] tf_cur_r [4];
  logic [7:0] tf_cur_nxt [4];
  logic [7:0] tf_prev_r [4];
  logic [7:0] tf_prev_nxt [4];
  logic [7:0] devh_r;
  logic [7:0] devh_nxt;
  logic high_byte_select_r;
  logic high_byte_select_nxt;
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status;
  logic busy;
  logic wr_ok;
  logic [1:0] tf_idx;
  logic fail_hit;

  dvr_walk_if #(.LBA_W(48), .CNT_W(16)) walk ();

  dvr_range_walk #(.LBA_W(48), .CNT_W(16)) u_walk (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wk(walk.walk)
  );

  assign busy = (state_r != ST_IDLE);
  // writes during a command are dropped, host must wait for busy low
  assign wr_ok = tf_wr_i && !busy;
  assign tf_idx = 2'(tf_addr_i - `DVR_A_SCNT);
  assign fail_hit = vfy_uncorr_i || vfy_id_missing_i;

  // address and count are taken straight from the register copies
  assign walk.start_lba = {tf_prev_r[3], tf_prev_r[2], tf_prev_r[1],
    tf_cur_r[3], tf_cur_r[2], tf_cur_r[1]};
  assign walk.start_cnt = {tf_prev_r[0], tf_cur_r[0]};

  always_comb begin
    status = 8'h00;
    status[`DVR_S_BUSY] = busy;
    status[`DVR_S_READY] = 1'b1;
    status[`DVR_S_SEEK_DONE] = !busy;
    // no data phase ever, so the data request bit stays low
    status[`DVR_S_DRQ] = 1'b0;
    status[`DVR_S_ERROR] = !busy && (err_r != 8'h00);
  end

  always_comb begin
    state_nxt = state_r;
    tf_cur_nxt = tf_cur_r;
    tf_prev_nxt = tf_prev_r;
    devh_nxt = devh_r;
    high_byte_select_nxt = high_byte_select_r;
    err_nxt = err_r;
    walk.load = 1'b0;
    walk.step = 1'b0;
    if (wr_ok) begin
      if (tf_addr_i >= `DVR_A_SCNT && tf_addr_i <= `DVR_A_CYLH) begin
        // each write pushes the old byte into the previous copy
        tf_prev_nxt[tf_idx] = tf_cur_r[tf_idx];
        tf_cur_nxt[tf_idx] = tf_wdata_i;
      end else if (tf_addr_i == `DVR_A_DEVH) begin
        devh_nxt = tf_wdata_i;
      end else if (tf_addr_i == `DVR_A_DEVCTL) begin
        high_byte_select_nxt = tf_wdata_i[`DVR_DC_HIGH_BYTE_SELECT];
      end else if (tf_addr_i == `DVR_A_CMD) begin
        err_nxt = 8'h00;
        if (tf_wdata_i == `DVR_OP_VERIFY_EXT) begin
          walk.load = 1'b1;
          state_nxt = ST_VREQ;
        end else if (tf_wdata_i[7:4] == `DVR_OP_RECAL_NIB) begin
          state_nxt = ST_SREQ;
        end else begin
          err_nxt[`DVR_E_ABORTED] = 1'b1;
        end
      end
    end
    case (state_r)
      ST_IDLE: begin
      end
      ST_VREQ: begin
        state_nxt = ST_VWAIT;
      end
      ST_VWAIT: begin
        if (vfy_done_i) begin
          if (fail_hit) begin
            err_nxt[`DVR_E_UNCORRECTABLE] = vfy_uncorr_i;
            err_nxt[`DVR_E_SECTOR_ID_MISSING] = vfy_id_missing_i;
            for (int i = 1; i < 4; i++) begin
              tf_cur_nxt[i] = walk.cur_lba[8*(i-1) +: 8];
              tf_prev_nxt[i] = walk.cur_lba[8*(i+2) +: 8];
            end
            state_nxt = ST_IDLE;
          end else if (walk.last) begin
            state_nxt = ST_IDLE;
          end else begin
            walk.step = 1'b1;
            state_nxt = ST_VREQ;
          end
        end
      end
      ST_SREQ: begin
        state_nxt = ST_SWAIT;
      end
      ST_SWAIT: begin
        if (seek_done_i) begin
          err_nxt[`DVR_E_TRACK_ZERO_MISSING] = seek_fail_i;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (tf_rd_i) begin
      if (tf_addr_i == `DVR_A_ERR) begin
        rdata_nxt = err_r;
      end else if (tf_addr_i >= `DVR_A_SCNT && tf_addr_i <= `DVR_A_CYLH) begin
        // select bit picks the previous copy: the high count byte or the upper half of the 48-bit address
        rdata_nxt = high_byte_select_r ? tf_prev_r[tf_idx] :
          tf_cur_r[tf_idx];
      end else if (tf_addr_i == `DVR_A_DEVH) begin
        rdata_nxt = devh_r;
      end else if (tf_addr_i == `DVR_A_CMD || tf_addr_i == `DVR_A_DEVCTL) begin
        rdata_nxt = status;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      for (int i = 0; i < 4; i++) begin
        tf_cur_r[i] <= `DVR_RST_BYTE;
        tf_prev_r[i] <= `DVR_RST_BYTE;
      end
      devh_r <= `DVR_RST_BYTE;
      high_byte_select_r <= 1'b0;
      err_r <= `DVR_RST_BYTE;
      rdata_r <= `DVR_RST_BYTE;
    end else if (ce_i) begin
      state_r <= state_nxt;
      tf_cur_r <= tf_cur_nxt;
      tf_prev_r <= tf_prev_nxt;
      devh_r <= devh_nxt;
      high_byte_select_r <= high_byte_select_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign tf_rdata_o = rdata_r;
  assign busy_o = busy;
  assign vfy_req_o = (state_r == ST_VREQ);
  assign vfy_lba_o = walk.cur_lba;
  assign seek_req_o = (state_r == ST_SREQ);

  a_vfy_no_data: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && vfy_req_o) |-> (busy_o && !status[`DVR_S_DRQ])
      ##1 !vfy_req_o)
    else $error("verify request not a lone pulse or with data request");

  a_fail_stops_vfy: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && state_r == ST_VWAIT && vfy_done_i && vfy_uncorr_i)
      |=> state_r == ST_IDLE && err_r[`DVR_E_UNCORRECTABLE] && !vfy_req_o)
    else $error("verify continued after uncorrectable sector");

  a_start_lba: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ok && tf_addr_i == `DVR_A_CMD
      && tf_wdata_i == `DVR_OP_VERIFY_EXT)
      |=> vfy_lba_o == $past(walk.start_lba) ##0 vfy_req_o)
    else $error("verify start address wrong");

  a_fail_address: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && state_r == ST_VWAIT && vfy_done_i && fail_hit)
      |=> {tf_prev_r[3], tf_cur_r[1]} ==
        {$past(vfy_lba_o[47:40]), $past(vfy_lba_o[7:0])})
    else $error("failing address not latched");

  a_recal_seek: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && wr_ok && tf_addr_i == `DVR_A_CMD
      && tf_wdata_i[7:4] == `DVR_OP_RECAL_NIB)
      |=> seek_req_o && busy_o)
    else $error("recalibrate did not request a seek");

  a_track_zero_flag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && state_r == ST_SWAIT && seek_done_i)
      |=> err_r[`DVR_E_TRACK_ZERO_MISSING] == $past(seek_fail_i)
        && !busy_o)
    else $error("track-zero-missing flag wrong after seek");

  a_done_status: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(busy_o) |-> status[`DVR_S_ERROR] ==
      (err_r[`DVR_E_UNCORRECTABLE] || err_r[`DVR_E_SECTOR_ID_MISSING]
        || err_r[`DVR_E_ABORTED] || err_r[`DVR_E_TRACK_ZERO_MISSING])
      && status[`DVR_S_SEEK_DONE] && !status[`DVR_S_BUSY])
    else $error("completion status does not match error flags");

  a_busy_ignores_wr: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (ce_i && busy_o && tf_wr_i) |=> $stable(tf_cur_r[0])
      && $stable(tf_prev_r[0]))
    else $error("register write accepted while busy");
endmodule // dvr_cmd_top

// ---- verif/dvr_media_model.sv ----
// behavioural medium verify engine and head positioner
module dvr_media_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // verify engine
  input wire logic vfy_req_i,
  input wire logic [47:0] vfy_lba_i,
  output logic vfy_done_o,
  output logic vfy_uncorr_o,
  output logic vfy_id_missing_o,
  // head positioner
  input wire logic seek_req_i,
  output logic seek_done_o,
  output logic seek_fail_o,
  // bench control and statistics
  input wire logic [3:0] lat_i,
  input wire logic [47:0] fail_lba_i,
  input wire logic [1:0] fail_kind_i,
  input wire logic seek_bad_i,
  output logic [16:0] req_cnt_o,
  output logic [47:0] last_lba_o,
  output logic [7:0] seek_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  logic pend_r;
  logic seek_r;
  logic junk_r;
  logic hit;
  // flags carry noise outside a done pulse, so only done qualifies them
  assign hit = last_lba_o == fail_lba_i;
  assign vfy_uncorr_o = vfy_done_o ? hit && fail_kind_i == 2'h1 : junk_r;
  assign vfy_id_missing_o = vfy_done_o ? hit && fail_kind_i == 2'h2 : ~junk_r;
  assign seek_fail_o = seek_done_o ? seek_bad_i : junk_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {wait_r, pend_r, seek_r, junk_r} <= '0;
      {vfy_done_o, seek_done_o, req_cnt_o, last_lba_o, seek_cnt_o} <= '0;
    end else begin
      junk_r <= ~junk_r;
      vfy_done_o <= 1'b0;
      seek_done_o <= 1'b0;
      req_cnt_o <= req_cnt_o + 17'(vfy_req_i);
      seek_cnt_o <= seek_cnt_o + 8'(seek_req_i);
      if (vfy_req_i) begin
        last_lba_o <= vfy_lba_i;
      end
      if (vfy_req_i || seek_req_i) begin
        pend_r <= 1'b1;
        seek_r <= seek_req_i;
        wait_r <= lat_i;
      end else if (pend_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        vfy_done_o <= ~seek_r;
        seek_done_o <= seek_r;
      end
    end
  end
endmodule // dvr_media_model

// ---- verif/tb.sv ----
// self-checking bench for the verify-ext and recalibrate command block
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, busy, vreq, vdone, vunc, vid, sreq, sdone, sfail;
  logic sbad, ce;
  logic [3:0] addr, lat;
  logic [7:0] wd, rdat, scnt;
  logic [47:0] vlba, flba, llba;
  logic [1:0] kind;
  logic [16:0] rcnt;
  int err_count, cmp_count, cyc;

  dvr_cmd_top dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .tf_wr_i(wr), .tf_rd_i(rd), .tf_addr_i(addr), .tf_wdata_i(wd),
    .tf_rdata_o(rdat), .busy_o(busy), .vfy_req_o(vreq), .vfy_lba_o(vlba),
    .vfy_done_i(vdone), .vfy_uncorr_i(vunc), .vfy_id_missing_i(vid),
    .seek_req_o(sreq), .seek_done_i(sdone), .seek_fail_i(sfail));
  dvr_media_model media (.core_clk_i(clk), .rst_i(rst), .vfy_req_i(vreq),
    .vfy_lba_i(vlba), .vfy_done_o(vdone), .vfy_uncorr_o(vunc),
    .vfy_id_missing_o(vid), .seek_req_i(sreq), .seek_done_o(sdone),
    .seek_fail_o(sfail), .lat_i(lat), .fail_lba_i(flba),
    .fail_kind_i(kind), .seek_bad_i(sbad), .req_cnt_o(rcnt),
    .last_lba_o(llba), .seek_cnt_o(scnt));

  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
    input string n);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    `CHK(n, e, rdat)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    // a command that never ends is a failure, not a pass
    if (busy !== 1'b0) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic t_idle();
    rd_chk(4'h1, 8'h00, "err");
    rd_chk(4'h7, 8'h50, "stat");
    rd_chk(4'h0, 8'h00, "data");
    rd_chk(4'hF, 8'h00, "unmapped");
    // enable low must swallow the write
    ce = 1'b0;
    wr_reg(4'h3, 8'h5A);
    ce = 1'b1;
    rd_chk(4'h3, 8'h00, "frozen");
  endtask

  // previous copy first, then current, for every byte register
  task automatic t_vfy(input logic [15:0] c, input logic [47:0] l,
    input logic [16:0] n, input logic [1:0] k);
    logic [16:0] r0;
    logic [7:0] s0;
    logic [47:0] e;
    r0 = rcnt;
    s0 = scnt;
    e = l + 48'(n) - 48'h1;
    flba = e;
    kind = k;
    for (int i = 0; i < 2; i++) begin
      wr_reg(4'h2, i ? c[7:0] : c[15:8]);
      for (int b = 0; b < 3; b++)
        wr_reg(4'(3 + b), l[8 * (3 * (1 - i) + b) +: 8]);
    end
    wr_reg(4'h7, `DVR_OP_VERIFY_EXT);
    wr_reg(4'h7, 8'h10);
    wr_reg(4'h2, ~c[7:0]);
    rd_chk(4'h7, 8'hC0, "busy stat");
    `CHK("busy", 1'b1, busy)
    wait_idle();
    `CHK("count", n, rcnt - r0)
    `CHK("last lba", e, llba)
    `CHK("seeks", s0, scnt)
    rd_chk(4'h1, k == 2'h1 ? 8'h40 : k == 2'h2 ? 8'h10 : 8'h00, "err");
    rd_chk(4'h7, k != 2'h0 ? 8'h51 : 8'h50, "stat");
    rd_chk(4'h2, c[7:0], "count");
    if (k != 2'h0) begin
      for (int h = 0; h < 2; h++) begin
        wr_reg(4'h8, h ? 8'h80 : 8'h00);
        for (int b = 0; b < 3; b++)
          rd_chk(4'(3 + b), e[8 * (3 * h + b) +: 8], "fail lba");
      end
      wr_reg(4'h8, 8'h00);
    end
  endtask

  task automatic t_recal();
    logic [7:0] s0;
    for (int i = 0; i < 16; i++) begin
      sbad = i[0];
      s0 = scnt;
      wr_reg(4'h7, {4'h1, 4'(i)});
      wait_idle();
      `CHK("seeks", s0 + 8'h1, scnt)
      rd_chk(4'h1, {6'h00, i[0], 1'b0}, "err");
      rd_chk(4'h7, {7'h28, i[0]}, "stat");
    end
  endtask

  task automatic t_abort();
    wr_reg(4'h7, 8'h20);
    wait_idle();
    rd_chk(4'h1, 8'h04, "err");
    rd_chk(4'h7, 8'h51, "stat");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {wr, rd, sbad} = 3'h0;
    {addr, wd, flba, kind} = '0;
    lat = 4'h4;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_idle();
    t_vfy(16'h0003, 48'hA1B2C3D4E5F6, 17'h3, 2'h0);
    lat = 4'h1;
    t_vfy(16'h0102, 48'h00000001FFF0, 17'h102, 2'h0);
    t_vfy(16'h0000, 48'h00FFFFFFFF00, 17'h3E8, 2'h1);
    t_vfy(16'h0005, 48'h123456789ABC, 17'h2, 2'h2);
    t_abort();
    t_recal();
    wrap_up();
  end
endmodule // tb
